// ---- shared/cpu_status_defs.vh ----
`ifndef CPU_STATUS_DEFS_VH
`define CPU_STATUS_DEFS_VH

// data address split
`define ADDR_W          12
`define BANK_W          5
`define OFFS_W          7
`define NUM_BANKS       32
// bank offsets
`define OFS_STATUS      7'h03
`define OFS_BANKSEL     7'h08
`define OFS_CORE_LAST   7'h0b
`define OFS_PERIPH_LO   7'h0c
`define OFS_PERIPH_HI   7'h1f
`define OFS_GRAM_LO     7'h20
`define OFS_GRAM_HI     7'h6f
`define OFS_COMMON_LO   7'h70
`define GRAM_PER_BANK   80
`define COMMON_BYTES    16
// linear window for indirect pointers
`define LIN_BASE        16'h2000
`define LIN_LIMIT       16'h29b0
// status fields
`define ST_WDT_EXP      4
`define ST_SLEEP        3
`define ST_NULL         2
`define ST_HCARRY       1
`define ST_CARRY        0
`define ST_RST_FLAGS    2'h3
`define ST_RST_ALU      3'h0
// ops
`define OP_NONE         3'h0
`define OP_ADD          3'h1
`define OP_SUB          3'h2
`define OP_LOGIC        3'h3

`endif

// ---- src/ram_store.v ----
`timescale 1ns/1ps
// registered-read byte memory
module ram_store #(
   parameter DEPTH = 2576,
   parameter AW    = 12
) (
   // clock
   input  wire          sys_clk,
   // write port
   input  wire          wrEn,
   input  wire [AW-1:0] wrAddr,
   input  wire [7:0]    wrData,
   // read port
   input  wire [AW-1:0] rdAddr,
   output reg  [7:0]    rdData
);
   reg [7:0] mem [0:DEPTH-1];

   always @(posedge sys_clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end
endmodule // ram_store

// ---- src/alu_flags.v ----
`timescale 1ns/1ps
`include "cpu_status_defs.vh"
// flag results of one alu op
module alu_flags (
   // operation
   input  wire [2:0] op,
   input  wire [7:0] opA,
   input  wire [7:0] opB,
   input  wire [7:0] logicRes,
   // results
   output reg  [7:0] result,
   output reg        nullFlag,
   output reg        halfCarry,
   output reg        carryOut
);
   reg [8:0] sum;
   reg [4:0] low;
   reg [7:0] addend;

   always @* begin
      // two's complement subtract
      addend = (op == `OP_SUB) ? (~opB + 8'h01) : opB;
      sum    = {1'b0, opA} + {1'b0, addend};
      low    = {1'b0, opA[3:0]} + {1'b0, addend[3:0]};
      if (op == `OP_SUB && opB == 8'h00) begin
         sum[8] = 1'b1;
         low[4] = 1'b1;
      end
      result = (op == `OP_LOGIC) ? logicRes : sum[7:0];
      nullFlag  = (result == 8'h00);
      halfCarry = low[4];
      carryOut  = sum[8];
   end
endmodule // alu_flags

// ---- src/cpu_status_flags_and_data_map.v ----
`timescale 1ns/1ps
`include "cpu_status_defs.vh"
//Contract
//- status bits 7 to 5 always read zero.
//- watchdog expiry bit is 1 after power-up, watchdog clear or sleep, 0 after time-out.
//- sleep entry bit is 1 after power-up or watchdog clear, 0 after a sleep.
//- power-on and brown-out set both reset flags and clear alu flags; other resets keep alu flags.
//- null result flag tracks whether an alu result is zero.
//- half carry is the carry out of bit 3 for add and subtract.
//- carry is the carry out of bit 7 for add and subtract.
//- subtraction adds the two's complement so carries act as inverted borrows.
//- bank offsets 0x0c to 0x1f are routed to the peripheral registers.
//- each bank has 80 bytes of general ram after the peripheral region.
//- 16 bytes of common ram appear at the same place in every bank.
//- indirect pointers reach the first 2480 bytes of general ram (banks 0 to 30) as one linear region.
//- alu flag writes to status are dropped when the op sets flags; reset flags never writable.
//- 32 banks of 128 bytes, chosen by the bank select register.
//- core registers occupy the first 12 offsets of every bank.
//- unimplemented locations read zero.
module cpu_status_flags_and_data_map (
   // clock and reset
   input  wire        sys_clk,
   input  wire        sys_rst,
   input  wire        powerOnRst,
   input  wire        brownOutRst,
   // core events
   input  wire        watchdogClearOp,
   input  wire        sleepOp,
   input  wire        watchdogTimeout,
   // alu op
   input  wire        aluValid,
   input  wire [2:0]  aluOp,
   input  wire [7:0]  aluA,
   input  wire [7:0]  aluB,
   input  wire [7:0]  aluLogicRes,
   output reg  [7:0]  aluResult,
   // data access
   input  wire        memWrEn,
   input  wire        memRdEn,
   input  wire        indirect,
   input  wire [6:0]  directOffs,
   input  wire [15:0] indirectPointer,
   input  wire [7:0]  memWrData,
   output reg  [7:0]  memRdData,
   output reg         memRdValid,
   // peripheral register port
   output reg         periphWrEn,
   output reg         periphRdEn,
   output reg  [11:0] periphAddr,
   output reg  [7:0]  periphWrData,
   input  wire [7:0]  periphRdData,
   // status view
   output wire [7:0]  cpuStatus,
   output wire [4:0]  bankSelect
);
   localparam GRAM_DEPTH = `NUM_BANKS * `GRAM_PER_BANK;
   localparam RAM_DEPTH  = GRAM_DEPTH + `COMMON_BYTES;
   // read source codes
   localparam SRC_ZERO   = 2'b00;
   localparam SRC_CORE   = 2'b01;
   localparam SRC_PERIPH = 2'b10;
   localparam SRC_RAM    = 2'b11;

   reg        wdtExp_q;
   reg        sleepFlag_q;
   reg [2:0]  aluFlags_q;
   reg [2:0]  aluFlags_d;
   reg [4:0]  bank_q;
   reg [1:0]  src_q;
   reg [7:0]  coreData_q;
   reg        rdPend_q;

   wire [7:0] sumRes;
   wire       nullF;
   wire       halfF;
   wire       carryF;
   wire [7:0] ramRd;

   reg [11:0] fullAddr;
   reg [4:0]  bank;
   reg [6:0]  offs;
   reg        linHit;
   reg [11:0] linIdx;
   reg [1:0]  src;
   reg [11:0] ramIdx;
   reg        ramHit;
   reg        flagsOp;

   // linear region decode
   function [12:0] lin_index;
      input [15:0] ptr;
      reg   [15:0] rel;
      begin
         rel = ptr - `LIN_BASE;
         if (ptr >= `LIN_BASE && ptr < `LIN_LIMIT) begin
            lin_index = {1'b1, rel[11:0]};
         end else begin
            lin_index = 13'h0000;
         end
      end
   endfunction

   // banked general ram index
   function [11:0] gram_index;
      input [4:0] bk;
      input [6:0] of;
      begin
         gram_index = bk * 12'd80 + {5'h00, of} - {5'h00, `OFS_GRAM_LO};
      end
   endfunction

   // core register slot match
   function core_hit;
      input [1:0] sel;
      input [6:0] of;
      input [6:0] slot;
      begin
         core_hit = (sel == SRC_CORE) && (of == slot);
      end
   endfunction

   // core register read value
   function [7:0] core_read;
      input [6:0] of;
      input [7:0] stat;
      input [4:0] bk;
      begin
         if (of == `OFS_STATUS) begin
            core_read = stat;
         end else if (of == `OFS_BANKSEL) begin
            core_read = {3'b000, bk};
         end else begin
            core_read = 8'h00;
         end
      end
   endfunction

   alu_flags u_alu (
      .op       (aluOp),
      .opA      (aluA),
      .opB      (aluB),
      .logicRes (aluLogicRes),
      .result   (sumRes),
      .nullFlag (nullF),
      .halfCarry(halfF),
      .carryOut (carryF)
   );

   ram_store #(.DEPTH(RAM_DEPTH), .AW(12)) u_ram (
      .sys_clk(sys_clk),
      .wrEn   (memWrEn && ramHit),
      .wrAddr (ramIdx),
      .wrData (memWrData),
      .rdAddr (ramIdx),
      .rdData (ramRd)
   );

   // address decode
   always @* begin
      linHit = 1'b0;
      linIdx = 12'h000;
      if (indirect) begin
         {linHit, linIdx} = lin_index(indirectPointer);
         fullAddr = indirectPointer[11:0];
      end else begin
         fullAddr = {bank_q, directOffs};
      end
      bank   = fullAddr[11:7];
      offs   = fullAddr[6:0];
      ramHit = 1'b0;
      ramIdx = 12'h000;
      src    = SRC_ZERO;
      if (linHit) begin
         ramHit = 1'b1;
         ramIdx = linIdx;
         src    = SRC_RAM;
      end else if (indirect && indirectPointer[15:12] != 4'h0) begin
         src = SRC_ZERO;
      end else if (offs <= `OFS_CORE_LAST) begin
         src = SRC_CORE;
      end else if (offs <= `OFS_PERIPH_HI) begin
         src = SRC_PERIPH;
      end else if (offs <= `OFS_GRAM_HI) begin
         ramHit = 1'b1;
         ramIdx = gram_index(bank, offs);
         src    = SRC_RAM;
      end else begin
         ramHit = 1'b1;
         ramIdx = GRAM_DEPTH[11:0] + {8'h00, offs[3:0]};
         src    = SRC_RAM;
      end
   end

   // peripheral strobes
   always @* begin
      periphWrEn   = memWrEn && (src == SRC_PERIPH);
      periphRdEn   = memRdEn && (src == SRC_PERIPH);
      periphAddr   = fullAddr;
      periphWrData = memWrData;
   end

   assign cpuStatus  = {3'b000, wdtExp_q, sleepFlag_q, aluFlags_q};
   assign bankSelect = bank_q;

   // core slot writes
   wire stWrite = memWrEn && core_hit(src, offs, `OFS_STATUS);
   wire bsWrite = memWrEn && core_hit(src, offs, `OFS_BANKSEL);

   always @* begin
      flagsOp    = aluValid && (aluOp != `OP_NONE);
      aluFlags_d = aluFlags_q;
      if (flagsOp) begin
         aluFlags_d[`ST_NULL] = nullF;
         if (aluOp != `OP_LOGIC) begin
            aluFlags_d[`ST_HCARRY] = halfF;
            aluFlags_d[`ST_CARRY]  = carryF;
         end
      end else if (stWrite) begin
         aluFlags_d = memWrData[2:0];
      end
   end

   // status and bank registers
   always @(posedge sys_clk) begin
      if (powerOnRst || brownOutRst) begin
         wdtExp_q    <= 1'b1;
         sleepFlag_q <= 1'b1;
         aluFlags_q  <= `ST_RST_ALU;
         bank_q      <= 5'h00;
      end else if (sys_rst) begin
         bank_q <= 5'h00;
      end else begin
         aluFlags_q <= aluFlags_d;
         if (bsWrite) begin
            bank_q <= memWrData[4:0];
         end
         if (watchdogTimeout) begin
            wdtExp_q <= 1'b0;
         end else if (watchdogClearOp || sleepOp) begin
            wdtExp_q <= 1'b1;
         end
         if (sleepOp) begin
            sleepFlag_q <= 1'b0;
         end else if (watchdogClearOp) begin
            sleepFlag_q <= 1'b1;
         end
      end
   end

   // read pipeline
   always @(posedge sys_clk) begin
      if (sys_rst || powerOnRst || brownOutRst) begin
         src_q      <= SRC_ZERO;
         coreData_q <= 8'h00;
         rdPend_q   <= 1'b0;
         aluResult  <= 8'h00;
      end else begin
         rdPend_q <= memRdEn;
         src_q    <= src;
         if (aluValid) begin
            aluResult <= sumRes;
         end
         coreData_q <= core_read(offs, cpuStatus, bank_q);
      end
   end

   // held so a peripheral read stands until the next one
   reg [7:0] periphHold_q;
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         periphHold_q <= 8'h00;
      end else if (periphRdEn) begin
         periphHold_q <= periphRdData;
      end
   end

   always @* begin
      memRdValid = rdPend_q;
      case (src_q)
         SRC_CORE:   memRdData = coreData_q;
         SRC_PERIPH: memRdData = periphHold_q;
         SRC_RAM:    memRdData = ramRd;
         default:    memRdData = 8'h00;
      endcase
   end
endmodule // cpu_status_flags_and_data_map

// ---- dv/status_map_asserts.sv ----
`timescale 1ns/1ps
module status_map_asserts (
   // clock and resets
   input wire logic       sys_clk,
   input wire logic       sys_rst,
   input wire logic       powerOnRst,
   input wire logic       brownOutRst,
   // core events
   input wire logic       watchdogClearOp,
   input wire logic       sleepOp,
   input wire logic       watchdogTimeout,
   // alu
   input wire logic       aluValid,
   input wire logic [2:0] aluOp,
   input wire logic [7:0] aluResult,
   // data access
   input wire logic       memRdEn,
   input wire logic       indirect,
   input wire logic [6:0] directOffs,
   input wire logic       periphRdEn,
   input wire logic [7:0] cpuStatus
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   wire noRst = !powerOnRst && !brownOutRst;
   wire dirRd = memRdEn && !indirect;

   a_upper_zero: assert property (cpuStatus[7:5] == 3'h0)
      else $error("upper status bits set");
   a_por_flags: assert property (powerOnRst |=> cpuStatus == 8'h18)
      else $error("power-on status wrong");
   a_bor_flags: assert property (brownOutRst |=> cpuStatus == 8'h18)
      else $error("brown-out status wrong");
   a_timeout_flag: assert property (noRst && watchdogTimeout |=> !cpuStatus[4])
      else $error("timeout kept expiry flag");
   a_sleep_flag: assert property (noRst && sleepOp && !watchdogTimeout
      |=> cpuStatus[4:3] == 2'b10)
      else $error("sleep flags wrong");
   a_clear_flags: assert property (noRst && watchdogClearOp && !sleepOp
      && !watchdogTimeout |=> cpuStatus[4:3] == 2'b11)
      else $error("clear flags wrong");
   a_null_result: assert property (noRst && aluValid && aluOp != 3'h0
      |=> cpuStatus[2] == (aluResult == 8'h00))
      else $error("null flag mismatch");
   a_periph_decode: assert property (dirRd && directOffs >= 7'h0c
      && directOffs <= 7'h1f |-> periphRdEn)
      else $error("peripheral not selected");
   a_ram_not_periph: assert property (dirRd && directOffs > 7'h1f |-> !periphRdEn)
      else $error("ram offset hit peripheral");
endmodule // status_map_asserts

bind cpu_status_flags_and_data_map status_map_asserts chk_u (.sys_clk, .sys_rst,
   .powerOnRst, .brownOutRst, .watchdogClearOp, .sleepOp, .watchdogTimeout,
   .aluValid, .aluOp, .aluResult, .memRdEn, .indirect, .directOffs, .periphRdEn,
   .cpuStatus);

// ---- dv/cpu_status_flags_and_data_map_tb.sv ----
`timescale 1ns/1ps
module cpu_status_flags_and_data_map_tb;
   logic sys_clk = 0, sys_rst = 1, powerOnRst = 1, brownOutRst = 0;
   logic watchdogClearOp = 0, sleepOp = 0, watchdogTimeout = 0, aluValid = 0;
   logic memWrEn = 0, memRdEn = 0, indirect = 0;
   logic [2:0]  aluOp = 0;
   logic [7:0]  aluA = 0, aluB = 0, aluLogicRes = 0, memWrData = 0;
   logic [6:0]  directOffs = 0;
   logic [15:0] indirectPointer = 0;
   wire  [7:0]  aluResult, memRdData, periphWrData, cpuStatus;
   wire  [11:0] periphAddr;
   wire  [4:0]  bankSelect;
   wire         memRdValid, periphWrEn, periphRdEn;
   wire  [7:0]  periphRdData = periphAddr[7:0] ^ 8'ha5;
   int n_errors = 0, total_checks = 0, cyc = 0;

   always #5 sys_clk = ~sys_clk;

   cpu_status_flags_and_data_map dut_u (.sys_clk, .sys_rst, .powerOnRst, .brownOutRst,
      .watchdogClearOp, .sleepOp, .watchdogTimeout, .aluValid, .aluOp, .aluA, .aluB,
      .aluLogicRes, .aluResult, .memWrEn, .memRdEn, .indirect, .directOffs,
      .indirectPointer, .memWrData, .memRdData, .memRdValid, .periphWrEn, .periphRdEn,
      .periphAddr, .periphWrData, .periphRdData, .cpuStatus, .bankSelect);

   task automatic chk(input logic [15:0] g, e);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic acc(input logic w, ind, input logic [6:0] o, input logic [15:0] p,
                      input logic [7:0] d);
      @(negedge sys_clk);
      {memWrEn, memRdEn, indirect, directOffs, indirectPointer, memWrData} =
         {w, !w, ind, o, p, d};
      @(negedge sys_clk);
      {memWrEn, memRdEn} = 2'b00;
   endtask

   task automatic rd(input logic ind, input logic [6:0] o, input logic [15:0] p,
                     input logic [7:0] e);
      acc(0, ind, o, p, 8'h00);
      chk({7'h0, memRdValid, memRdData}, {8'h1, e});
   endtask

   task automatic wr(input logic [6:0] o, input logic [7:0] d);
      acc(1, 0, o, 16'h0, d);
   endtask

   task automatic st(input logic [7:0] e);
      rd(0, 7'h03, 16'h0, e);
   endtask

   // por, bor, clear, sleep, timeout
   task automatic ev(input logic [4:0] s);
      @(negedge sys_clk);
      {powerOnRst, brownOutRst, watchdogClearOp, sleepOp, watchdogTimeout} = s;
      @(negedge sys_clk);
      {powerOnRst, brownOutRst, watchdogClearOp, sleepOp, watchdogTimeout} = 5'h00;
   endtask

   task automatic alu(input logic [2:0] op, input logic [7:0] a, b, l);
      @(negedge sys_clk);
      {aluValid, aluOp, aluA, aluB, aluLogicRes} = {1'b1, op, a, b, l};
      @(negedge sys_clk);
      aluValid = 0;
   endtask

   task automatic t_reset;
      ev(5'h10);
      st(8'h18);
      alu(3'h1, 8'hff, 8'h01, 8'h00);
      st(8'h1f);
      @(negedge sys_clk);
      sys_rst = 1;
      @(negedge sys_clk);
      sys_rst = 0;
      st(8'h1f);
      ev(5'h08);
      st(8'h18);
      $display("t_reset done");
   endtask

   task automatic t_events;
      ev(5'h01);
      st(8'h08);
      ev(5'h02);
      st(8'h10);
      ev(5'h04);
      st(8'h18);
      ev(5'h05);
      st(8'h08);
      ev(5'h04);
      st(8'h18);
      $display("t_events done");
   endtask

   task automatic t_alu;
      logic [37:0] tbl [8] = '{
         {3'h1, 8'h0f, 8'h01, 8'h00, 8'h10, 3'b010}, {3'h1, 8'hf0, 8'h10, 8'h00, 8'h00, 3'b101},
         {3'h2, 8'h05, 8'h03, 8'h00, 8'h02, 3'b011}, {3'h2, 8'h03, 8'h05, 8'h00, 8'hfe, 3'b000},
         {3'h2, 8'h10, 8'h01, 8'h00, 8'h0f, 3'b001}, {3'h2, 8'h07, 8'h07, 8'h00, 8'h00, 3'b111},
         {3'h3, 8'h00, 8'h00, 8'h00, 8'h00, 3'b111}, {3'h3, 8'h12, 8'h34, 8'h5a, 8'h5a, 3'b011}};
      foreach (tbl[i]) begin
         alu(tbl[i][37:35], tbl[i][34:27], tbl[i][26:19], tbl[i][18:11]);
         chk({8'h0, aluResult}, {8'h0, tbl[i][10:3]});
         st({5'h03, tbl[i][2:0]});
      end
      $display("t_alu done");
   endtask

   task automatic t_write;
      ev(5'h01);
      wr(7'h03, 8'hff);
      st(8'h0f);
      wr(7'h03, 8'h00);
      st(8'h08);
      @(negedge sys_clk);
      {memWrEn, directOffs, memWrData, aluValid, aluOp, aluA, aluB} =
         {1'b1, 7'h03, 8'h07, 1'b1, 3'h1, 8'h01, 8'h01};
      @(negedge sys_clk);
      {memWrEn, aluValid} = 2'b00;
      chk({8'h0, cpuStatus}, 16'h0008);
      ev(5'h04);
      $display("t_write done");
   endtask

   task automatic t_map;
      wr(7'h08, 8'h03);
      rd(0, 7'h08, 16'h0, 8'h03);
      wr(7'h70, 8'h3c);
      wr(7'h20, 8'h33);
      st(8'h18);
      wr(7'h08, 8'h00);
      rd(0, 7'h70, 16'h0, 8'h3c);
      wr(7'h6f, 8'h22);
      rd(1, 7'h00, 16'h20f0, 8'h33);
      rd(1, 7'h00, 16'h204f, 8'h22);
      rd(0, 7'h01, 16'h0, 8'h00);
      rd(1, 7'h00, 16'h1000, 8'h00);
      rd(0, 7'h1f, 16'h0, 8'hba);
      wr(7'h08, 8'h05);
      chk({11'h0, bankSelect}, 16'h0005);
      @(negedge sys_clk);
      {memWrEn, indirect, directOffs, memWrData} = {1'b1, 1'b0, 7'h0c, 8'h5e};
      #1 chk({3'h0, periphWrEn, periphAddr}, 16'h128c);
      chk({7'h0, periphRdEn, periphWrData}, 16'h005e);
      @(negedge sys_clk);
      memWrEn = 0;
      $display("t_map done");
   endtask

   task automatic final_report;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc > 2000) begin
         n_errors++;
         final_report;
      end
   end

   initial begin
      repeat (5) @(negedge sys_clk);
      {sys_rst, powerOnRst} = 2'b00;
      t_reset;
      t_events;
      t_alu;
      t_write;
      t_map;
      final_report;
   end
endmodule // cpu_status_flags_and_data_map_tb
